/* common/ssa_pkg.sv */
// Constants and types for the subtract and swap datapath
// Functional notes
// - The literal subtract takes the low eight instruction bits minus the accumulator.
// - The literal subtract always writes the accumulator and never a file register.
// - The file subtract takes the file register at the 7-bit address minus the accumulator.
// - For file instructions destination bit 0 writes the accumulator and 1 the file register.
// - A positive difference sets carry to 1 since no borrow occurred.
// - Equal operands giving a zero difference also set carry to 1.
// - A negative difference clears carry and the result wraps modulo 256.
// - The nibble exchange puts the low nibble high and the high nibble low.
// - The nibble exchange leaves carry, half carry and zero unchanged.
package ssa_pkg;
    localparam int INSTR_W = 14;
    localparam int DATA_W = 8;
    localparam int ADDR_W = 7;
    localparam int NIB_W = 4;
    localparam int DEST_BIT = 7;
    localparam logic [4:0] LIT_SUB_OPC = 5'h1e;
    localparam logic [5:0] FILE_SUB_OPC = 6'h02;
    localparam logic [5:0] SWAP_OPC = 6'h0e;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic FLAG_RESET = 1'b0;
    localparam int OP_CYCLES = 1;

    typedef enum logic [1:0] {
        SSA_OP_NONE = 2'h0,
        SSA_OP_LIT = 2'h1,
        SSA_OP_FILE = 2'h3,
        SSA_OP_SWAP = 2'h2
    } ssa_op_t;

    function automatic ssa_op_t ssa_decode(input logic [INSTR_W-1:0] word);
        ssa_op_t op;
        op = SSA_OP_NONE;
        if (word[13:9] == LIT_SUB_OPC) begin
            op = SSA_OP_LIT;
        end else if (word[13:8] == FILE_SUB_OPC) begin
            op = SSA_OP_FILE;
        end else if (word[13:8] == SWAP_OPC) begin
            op = SSA_OP_SWAP;
        end
        return op;
    endfunction : ssa_decode
endpackage : ssa_pkg

/* common/ssa_alu_if.sv */
// Operand and result bundle between the control and the arithmetic unit
`timescale 1ns/1ns
interface ssa_alu_if;
    logic [ssa_pkg::DATA_W-1:0] operandA;
    logic [ssa_pkg::DATA_W-1:0] accIn;
    logic doSwap;
    logic [ssa_pkg::DATA_W-1:0] result;
    logic carryOut;
    logic halfCarryOut;
    logic zeroOut;
    modport core (input operandA, input accIn, input doSwap,
                  output result, output carryOut, output halfCarryOut, output zeroOut);
    modport user (output operandA, output accIn, output doSwap,
                  input result, input carryOut, input halfCarryOut, input zeroOut);
endinterface : ssa_alu_if

/* verilog/ssa_alu_core.sv */
// Combinational subtract and nibble exchange unit
`timescale 1ns/1ns
module ssa_alu_core (
    ssa_alu_if.core alu
);
    logic [ssa_pkg::DATA_W:0] diff;
    logic [ssa_pkg::NIB_W:0] lowDiff;

    // Operand minus accumulator, carry is the inverted borrow
    assign diff = {1'b0, alu.operandA} + {1'b0, ~alu.accIn} + 9'h001;
    assign lowDiff = {1'b0, alu.operandA[3:0]} + {1'b0, ~alu.accIn[3:0]} + 5'h01;

    always_comb begin
        if (alu.doSwap) begin
            alu.result = {alu.operandA[3:0], alu.operandA[7:4]};
        end else begin
            alu.result = diff[ssa_pkg::DATA_W-1:0];
        end
    end

    assign alu.carryOut = diff[ssa_pkg::DATA_W];
    assign alu.halfCarryOut = lowDiff[ssa_pkg::NIB_W];
    assign alu.zeroOut = (diff[ssa_pkg::DATA_W-1:0] == 8'h00);
endmodule : ssa_alu_core

/* verilog/ssa_datapath.sv */
// Execution datapath for literal subtract, file subtract and nibble exchange
`timescale 1ns/1ns
module ssa_datapath (
    input wire logic clk,
    input wire logic resetn,
    input wire logic instrValid,
    input wire logic [ssa_pkg::INSTR_W-1:0] instrWord,
    output logic [ssa_pkg::ADDR_W-1:0] fileRdAddr,
    input wire logic [ssa_pkg::DATA_W-1:0] fileRdData,
    input wire logic accLoad,
    input wire logic [ssa_pkg::DATA_W-1:0] accLoadData,
    output logic fileWrEn,
    output logic [ssa_pkg::ADDR_W-1:0] fileWrAddr,
    output logic [ssa_pkg::DATA_W-1:0] fileWrData,
    output logic [ssa_pkg::DATA_W-1:0] acc,
    output logic carryFlag,
    output logic halfCarryFlag,
    output logic zeroFlag,
    output logic opDone
);
    ssa_alu_if alu ();

    ssa_pkg::ssa_op_t opKind;
    logic isLit;
    logic isFile;
    logic isSwap;
    logic isSub;
    logic destFile;
    logic toAcc;
    logic toFile;

    logic [ssa_pkg::DATA_W-1:0] acc_q;
    logic [ssa_pkg::DATA_W-1:0] acc_d;
    logic carry_q;
    logic halfCarry_q;
    logic zero_q;
    logic fileWrEn_q;
    logic [ssa_pkg::ADDR_W-1:0] fileWrAddr_q;
    logic [ssa_pkg::DATA_W-1:0] fileWrData_q;
    logic opDone_q;

    // Instruction decode
    assign opKind = instrValid ? ssa_pkg::ssa_decode(instrWord) : ssa_pkg::SSA_OP_NONE;
    assign isLit = (opKind == ssa_pkg::SSA_OP_LIT);
    assign isFile = (opKind == ssa_pkg::SSA_OP_FILE);
    assign isSwap = (opKind == ssa_pkg::SSA_OP_SWAP);
    assign isSub = isLit || isFile;
    assign destFile = instrWord[ssa_pkg::DEST_BIT];
    assign fileRdAddr = instrWord[ssa_pkg::ADDR_W-1:0];

    // Destination steering
    assign toFile = (isFile || isSwap) && destFile;
    assign toAcc = isLit || ((isFile || isSwap) && !destFile);

    // Operand selection, bit 8 of the literal form ignored
    assign alu.operandA = isLit ? instrWord[ssa_pkg::DATA_W-1:0] : fileRdData;
    assign alu.accIn = acc_q;
    assign alu.doSwap = isSwap;

    ssa_alu_core u_core (
        .alu(alu.core)
    );

    always_comb begin
        if (toAcc) begin
            acc_d = alu.result;
        end else if (accLoad) begin
            acc_d = accLoadData;
        end else begin
            acc_d = acc_q;
        end
    end

    // Accumulator
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            acc_q <= ssa_pkg::ACC_RESET;
        end else begin
            acc_q <= acc_d;
        end
    end

    // Status flags, only the subtractions touch them
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            carry_q <= ssa_pkg::FLAG_RESET;
            halfCarry_q <= ssa_pkg::FLAG_RESET;
            zero_q <= ssa_pkg::FLAG_RESET;
        end else if (isSub) begin
            carry_q <= alu.carryOut;
            halfCarry_q <= alu.halfCarryOut;
            zero_q <= alu.zeroOut;
        end
    end

    // File register write port
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            fileWrEn_q <= 1'b0;
            fileWrAddr_q <= '0;
            fileWrData_q <= '0;
        end else begin
            fileWrEn_q <= toFile;
            if (toFile) begin
                fileWrAddr_q <= instrWord[ssa_pkg::ADDR_W-1:0];
                fileWrData_q <= alu.result;
            end
        end
    end

    // Completion strobe
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            opDone_q <= 1'b0;
        end else begin
            opDone_q <= isSub || isSwap;
        end
    end

    assign acc = acc_q;
    assign carryFlag = carry_q;
    assign halfCarryFlag = halfCarry_q;
    assign zeroFlag = zero_q;
    assign fileWrEn = fileWrEn_q;
    assign fileWrAddr = fileWrAddr_q;
    assign fileWrData = fileWrData_q;
    assign opDone = opDone_q;

    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!resetn);

    lit_sub_value_a: assert property (
        isLit |=> acc == $past(instrWord[7:0]) - $past(acc))
        else $error("Literal subtract result wrong");

    lit_no_file_a: assert property (
        isLit |=> !fileWrEn)
        else $error("Literal subtract wrote a file register");

    file_sub_value_a: assert property (
        isFile && destFile |=> fileWrEn && fileWrData == $past(fileRdData) - $past(acc)
            && fileWrAddr == $past(instrWord[6:0]))
        else $error("File subtract result or address wrong");

    dest_acc_a: assert property (
        (isFile || isSwap) && !destFile |=> !fileWrEn
            && acc == ($past(isSwap) ? {$past(fileRdData[3:0]), $past(fileRdData[7:4])}
            : $past(fileRdData) - $past(acc)))
        else $error("Destination zero did not write the accumulator");

    dest_file_a: assert property (
        (isFile || isSwap) && destFile && !accLoad |=> acc == $past(acc))
        else $error("Destination one changed the accumulator");

    carry_no_borrow_a: assert property (
        isSub && alu.operandA > acc |=> carryFlag)
        else $error("Carry clear on positive difference");

    carry_equal_a: assert property (
        isSub && alu.operandA == acc |=> carryFlag && zeroFlag)
        else $error("Carry or zero clear on equal operands");

    carry_borrow_a: assert property (
        isSub && alu.operandA < acc |=> !carryFlag && !zeroFlag)
        else $error("Carry set on negative difference");

    swap_nibbles_a: assert property (
        isSwap && !destFile |=> acc == {$past(fileRdData[3:0]), $past(fileRdData[7:4])})
        else $error("Nibble exchange result wrong");

    swap_flags_a: assert property (
        !isSub |=> $stable({carryFlag, halfCarryFlag, zeroFlag}))
        else $error("Flags changed without a subtraction");

    half_carry_a: assert property (
        isSub |=> halfCarryFlag == ($past(alu.operandA[3:0]) >= $past(acc[3:0])))
        else $error("Half carry wrong");

    one_cycle_a: assert property (
        (isSub || isSwap) |=> opDone ##1 (opDone == $past(isSub || isSwap)))
        else $error("Completion strobe misplaced");

    zero_flag_a: assert property (
        isSub |=> zeroFlag == ($past(alu.operandA) == $past(acc)))
        else $error("Zero flag wrong");

    swap_to_file_a: assert property (
        isSwap && destFile |=> fileWrEn && fileWrAddr == $past(instrWord[6:0])
            && fileWrData == {$past(fileRdData[3:0]), $past(fileRdData[7:4])})
        else $error("Nibble exchange to file wrong");

    lit_decode_a: assert property (
        instrValid && instrWord[13:9] == 5'h1e |-> isLit)
        else $error("Literal subtract not decoded");

    file_decode_a: assert property (
        instrValid && instrWord[13:8] == 6'h02 |-> isFile)
        else $error("File subtract not decoded");

    swap_decode_a: assert property (
        instrValid && instrWord[13:8] == 6'h0e |-> isSwap)
        else $error("Nibble exchange not decoded");

    idle_quiet_a: assert property (
        !(isSub || isSwap) |=> !opDone && !fileWrEn)
        else $error("Strobe without an instruction");

    idle_acc_a: assert property (
        !toAcc && !accLoad |=> acc == $past(acc))
        else $error("Accumulator changed without a writer");

    acc_load_a: assert property (
        accLoad && !toAcc |=> acc == $past(accLoadData))
        else $error("Accumulator preset lost");

    wr_hold_a: assert property (
        !toFile |=> $stable(fileWrAddr) && $stable(fileWrData))
        else $error("File write port changed without a write");

    lit_keeps_file_a: assert property (
        isLit |=> $stable(fileWrAddr) && $stable(fileWrData))
        else $error("Literal subtract touched the file write port");

    lit_pos_c: cover property (isLit && instrWord[7:0] > acc);
    lit_zero_c: cover property (isLit && instrWord[7:0] == acc);
    file_neg_c: cover property (isFile && destFile && fileRdData < acc);
    swap_acc_c: cover property (isSwap && !destFile);
    back_to_back_c: cover property (isFile ##1 isSwap);
endmodule : ssa_datapath

/* dv/ssa_datapath_bench.sv */
// Self-checking bench for the subtract and swap datapath
`timescale 1ns/1ns
module ssa_datapath_bench;
    logic clk = 1'b0;
    logic resetn = 1'b0;
    logic instrValid = 1'b0;
    logic [13:0] instrWord = 14'h0000;
    logic accLoad = 1'b0;
    logic [7:0] accLoadData = 8'h00;
    logic [6:0] fileRdAddr;
    logic [6:0] fileWrAddr;
    logic [7:0] fileRdData;
    logic [7:0] fileWrData;
    logic [7:0] acc;
    logic fileWrEn;
    logic carryFlag;
    logic halfCarryFlag;
    logic zeroFlag;
    logic opDone;
    logic [7:0] regFile [128];
    logic [7:0] expAcc = 8'h00;
    logic [2:0] expFlags = 3'h0;
    int errors = 0;
    int n_compared = 0;
    int cycles = 0;

    ssa_datapath dut (.clk(clk), .resetn(resetn), .instrValid(instrValid),
        .instrWord(instrWord), .fileRdAddr(fileRdAddr), .fileRdData(fileRdData),
        .accLoad(accLoad), .accLoadData(accLoadData), .fileWrEn(fileWrEn),
        .fileWrAddr(fileWrAddr), .fileWrData(fileWrData), .acc(acc),
        .carryFlag(carryFlag), .halfCarryFlag(halfCarryFlag), .zeroFlag(zeroFlag),
        .opDone(opDone));

    // Register file with combinational read
    assign fileRdData = regFile[fileRdAddr];
    always @(posedge clk) begin
        if (fileWrEn === 1'b1) regFile[fileWrAddr] <= fileWrData;
    end

    initial forever #50 clk = ~clk;

    always @(posedge clk) begin
        cycles++;
        if (cycles == 500) begin
            errors++;
            print_verdict();
        end
    end

    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        n_compared++;
        if (g !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // Preset accumulator; called and returns at a falling edge
    task automatic load(input logic [7:0] v);
        instrValid = 1'b0;
        accLoad = 1'b1;
        accLoadData = v;
        @(negedge clk);
        accLoad = 1'b0;
        expAcc = v;
        chk("acc", v, acc);
    endtask : load

    // One instruction; leaves it presented so the next can follow at once
    task automatic exec(input logic [13:0] w);
        logic [7:0] o;
        logic [7:0] r;
        logic [8:0] d;
        logic lit;
        logic fil;
        logic swp;
        logic toF;
        lit = w[13:9] == 5'h1e;
        fil = w[13:8] == 6'h02;
        swp = w[13:8] == 6'h0e;
        o = lit ? w[7:0] : regFile[w[6:0]];
        d = {1'b0, o} - {1'b0, expAcc};
        r = swp ? {o[3:0], o[7:4]} : d[7:0];
        toF = !lit && w[7];
        instrValid = 1'b1;
        instrWord = w;
        @(negedge clk);
        chk("fileRdAddr", {1'b0, w[6:0]}, {1'b0, fileRdAddr});
        if (lit || fil) expFlags = {~d[8], o[3:0] >= expAcc[3:0], d[7:0] == 8'h00};
        if ((lit || fil || swp) && !toF) expAcc = r;
        chk("opDone", {7'h00, lit || fil || swp}, {7'h00, opDone});
        chk("fileWrEn", {7'h00, (fil || swp) && toF}, {7'h00, fileWrEn});
        if ((fil || swp) && toF) begin
            chk("fileWrAddr", {1'b0, w[6:0]}, {1'b0, fileWrAddr});
            chk("fileWrData", r, fileWrData);
        end
        chk("acc", expAcc, acc);
        chk("flags", {5'h00, expFlags}, {5'h00, carryFlag, halfCarryFlag, zeroFlag});
    endtask : exec

    task automatic print_verdict;
        if (errors == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : print_verdict

    initial begin
        foreach (regFile[i]) regFile[i] = 8'h00;
        regFile[5] = 8'h03;
        regFile[6] = 8'h02;
        regFile[8] = 8'h10;
        regFile[9] = 8'h01;
        regFile[126] = 8'h3c;
        regFile[127] = 8'ha5;
        repeat (10) @(negedge clk);
        chk("acc", 8'h00, acc);
        chk("resetOut", 8'h00, {3'h0, fileWrEn, opDone, carryFlag, halfCarryFlag, zeroFlag});
        resetn = 1'b1;
        // File forms back to back, then swaps and ignored words
        load(8'h02);
        exec(14'h0285);
        exec(14'h0206);
        exec(14'h0eff);
        exec(14'h0e7e);
        exec(14'h0000);
        exec(14'h0c05);
        load(8'h01);
        exec(14'h0208);
        load(8'h02);
        exec(14'h0289);
        // Literal forms, bit 8 both ways
        load(8'h01);
        exec(14'h3c02);
        load(8'h02);
        exec(14'h3d02);
        load(8'h03);
        exec(14'h3c02);
        load(8'h01);
        exec(14'h3cff);
        exec(14'h3a02);
        instrValid = 1'b0;
        @(negedge clk);
        chk("swapped", 8'h5a, regFile[127]);
        chk("wrapped", 8'hff, regFile[9]);
        // Reset in mid-run, then an instruction at the first edge after release
        resetn = 1'b0;
        @(negedge clk);
        chk("resetAcc", 8'h00, acc);
        chk("resetWrAddr", 8'h00, {1'b0, fileWrAddr});
        chk("resetWrData", 8'h00, fileWrData);
        chk("resetFlags", 8'h00, {5'h00, carryFlag, halfCarryFlag, zeroFlag});
        expAcc = 8'h00;
        expFlags = 3'h0;
        resetn = 1'b1;
        exec(14'h3c05);
        instrValid = 1'b0;
        @(negedge clk);
        print_verdict();
    end
endmodule : ssa_datapath_bench
